// file: rtl/lccr_pkg.sv
// Purpose: constants and carriers for the local configuration/control register
// Assumes: one 32-bit register at window offset 0x00, PCI clock domain
// Notes:   bit positions, offsets and reset values live here only
package lccr_pkg;
   // ==========================================================
   // offsets and widths
   localparam int          LCCR_ADDR_W     = 8;
   localparam logic [7:0]  LCCR_OFS_CTRL   = 8'h00;
   // ==========================================================
   // field positions
   localparam int          LCCR_B_MODE_LO  = 0;
   localparam int          LCCR_B_MODE_HI  = 1;
   localparam int          LCCR_B_XTAL_EN  = 2;
   localparam int          LCCR_B_LANE_LO  = 3;
   localparam int          LCCR_B_LANE_HI  = 4;
   localparam int          LCCR_B_WAKE_EN  = 7;
   localparam int          LCCR_B_ROM_CLK  = 24;
   localparam int          LCCR_B_ROM_SEL  = 25;
   localparam int          LCCR_B_ROM_DO   = 26;
   localparam int          LCCR_B_ROM_DI   = 27;
   localparam int          LCCR_B_ROM_OK   = 28;
   localparam int          LCCR_B_RELOAD   = 29;
   // ==========================================================
   // reset values
   localparam logic        LCCR_RST_BIT    = 1'b0;
   localparam logic [1:0]  LCCR_RST_LANE   = 2'h0;
   localparam logic [31:0] LCCR_ZERO32     = 32'h0000_0000;

   // ==========================================================
   // request carrier: one access through either window
   typedef struct packed {
      logic                   valid;
      logic                   mem;    // 1: memory window, 0: i/o window
      logic                   wr;
      logic [LCCR_ADDR_W-1:0] addr;
      logic [3:0]             be;
      logic [31:0]            wdata;
   } lccr_req_t;

   // eeprom-loadable fields, written by the configuration loader
   typedef struct packed {
      logic       we;
      logic       xtal_en;
      logic [1:0] lane;
      logic       wake_en;
   } lccr_load_t;
endpackage

// file: rtl/lccr_ctrl.sv
// Purpose: local configuration and control register of the pci target bridge
// Assumes: accesses arrive already decoded to the i/o or memory window
// Notes:   answer one cycle after each request; pin inputs are synchronised
`timescale 1ns/100ps
module lccr_ctrl
   import lccr_pkg::*;
(
   // clock and reset
   input  wire logic       CLOCK,
   input  wire logic       RSTN,
   // register access
   input  wire lccr_req_t  REQ,
   output logic            ACK,
   output logic            ERR,
   output logic [31:0]     RDATA,
   // configuration loader
   input  wire lccr_load_t LOAD,
   input  wire logic       ROM_VALID,
   input  wire logic       LOAD_DONE,
   output logic            RELOAD_START,
   // pins
   input  wire logic [1:0] MODE_PINS,
   input  wire logic       XTAL_OSC,
   output logic            CRYSTAL_CLOCK_OUTPUT_PIN,
   output logic            SERIAL_ROM_CLOCK_PIN,
   output logic            SERIAL_ROM_SELECT_PIN,
   output logic            SERIAL_ROM_DATA_OUT_PIN,
   input  wire logic       SERIAL_ROM_DATA_IN_PIN,
   input  wire logic       MULTIPURPOSE_PIN_TWO,
   // local bus side
   input  wire logic       BUS_IS_32,
   input  wire logic       WAKE_POLARITY,
   output logic [3:0]      MEM8_LANE_ONEHOT,
   output logic            WAKE_SET
);

   // ==========================================================
   // helpers
   function automatic logic [31:0] swap32(input logic [31:0] d);
      swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
   endfunction

   function automatic logic onehot4(input logic [3:0] b);
      onehot4 = (b == 4'h1) || (b == 4'h2) || (b == 4'h4) || (b == 4'h8);
   endfunction

   // ==========================================================
   // pin synchronisers
   logic [1:0] mode_s1, mode_s2;
   logic       osc_s1, osc_s2, di_s1, di_s2, mio_s1, mio_s2;

   always_ff @(posedge CLOCK) begin
      mode_s1 <= MODE_PINS;
      mode_s2 <= mode_s1;
      osc_s1  <= XTAL_OSC;
      osc_s2  <= osc_s1;
      di_s1   <= SERIAL_ROM_DATA_IN_PIN;
      di_s2   <= di_s1;
      mio_s1  <= MULTIPURPOSE_PIN_TWO;
      mio_s2  <= mio_s1;
   end

   // ==========================================================
   // decode
   logic        xtal_en_r, wake_en_r, rom_clk_r, rom_sel_r, rom_do_r, reload_r;
   logic [1:0]  lane_r;
   logic        hit, bad_io;
   logic [3:0]  wmask;
   logic [31:0] wdata_reg, img, rd_bus;
   logic        set_reload;

   always_comb begin
      hit       = (REQ.addr[LCCR_ADDR_W-1:2] == LCCR_OFS_CTRL[LCCR_ADDR_W-1:2]);
      bad_io    = !REQ.mem && !onehot4(REQ.be);
      // memory lanes carry the register bytes in reversed order
      wdata_reg = REQ.mem ? swap32(REQ.wdata) : REQ.wdata;
      wmask     = REQ.mem ? {REQ.be[0], REQ.be[1], REQ.be[2], REQ.be[3]} : REQ.be;
      if (!(REQ.valid && REQ.wr && hit && !bad_io)) begin
         wmask = 4'h0;
      end
      img                 = LCCR_ZERO32;
      img[LCCR_B_MODE_HI:LCCR_B_MODE_LO] = mode_s2;
      img[LCCR_B_XTAL_EN] = xtal_en_r;
      img[LCCR_B_LANE_HI:LCCR_B_LANE_LO] = lane_r;
      img[LCCR_B_WAKE_EN] = wake_en_r;
      img[LCCR_B_ROM_CLK] = rom_clk_r;
      img[LCCR_B_ROM_SEL] = rom_sel_r;
      img[LCCR_B_ROM_DO]  = rom_do_r;
      img[LCCR_B_ROM_DI]  = di_s2;
      img[LCCR_B_ROM_OK]  = ROM_VALID;
      img[LCCR_B_RELOAD]  = reload_r;
      rd_bus = REQ.mem ? swap32(img) : (img & {{8{REQ.be[3]}}, {8{REQ.be[2]}},
                                              {8{REQ.be[1]}}, {8{REQ.be[0]}}});
      set_reload = wmask[3] && wdata_reg[LCCR_B_RELOAD];
   end

   // ==========================================================
   // access answer
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         ACK   <= 1'b0;
         ERR   <= 1'b0;
         RDATA <= LCCR_ZERO32;
      end else begin
         ACK <= REQ.valid;
         ERR <= REQ.valid && bad_io;
         if (REQ.valid && !REQ.wr) begin
            RDATA <= (hit && !bad_io) ? rd_bus : LCCR_ZERO32;
         end
      end
   end

   // ==========================================================
   // loadable control fields: pci write wins over the loader
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         xtal_en_r <= LCCR_RST_BIT;
         lane_r    <= LCCR_RST_LANE;
         wake_en_r <= LCCR_RST_BIT;
      end else if (wmask[0]) begin
         xtal_en_r <= wdata_reg[LCCR_B_XTAL_EN];
         lane_r    <= wdata_reg[LCCR_B_LANE_HI:LCCR_B_LANE_LO];
         wake_en_r <= wdata_reg[LCCR_B_WAKE_EN];
      end else if (LOAD.we) begin
         xtal_en_r <= LOAD.xtal_en;
         lane_r    <= LOAD.lane;
         wake_en_r <= LOAD.wake_en;
      end
   end

   // ==========================================================
   // serial rom bit-banging; protocol timing is left to software
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         rom_clk_r <= LCCR_RST_BIT;
         rom_sel_r <= LCCR_RST_BIT;
         rom_do_r  <= LCCR_RST_BIT;
      end else if (wmask[3]) begin
         rom_clk_r <= wdata_reg[LCCR_B_ROM_CLK];
         rom_sel_r <= wdata_reg[LCCR_B_ROM_SEL];
         rom_do_r  <= wdata_reg[LCCR_B_ROM_DO];
      end
   end

   // ==========================================================
   // reload request; a reload write beats a completing load, but RELOAD_START pulses only if the bit was clear
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         reload_r     <= LCCR_RST_BIT;
         RELOAD_START <= 1'b0;
      end else begin
         RELOAD_START <= set_reload && !reload_r;
         if (set_reload) begin
            reload_r <= 1'b1;
         end else if (LOAD_DONE) begin
            reload_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // pin outputs
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         CRYSTAL_CLOCK_OUTPUT_PIN <= 1'b0;
         SERIAL_ROM_CLOCK_PIN     <= 1'b0;
         SERIAL_ROM_SELECT_PIN    <= 1'b0;
         SERIAL_ROM_DATA_OUT_PIN  <= 1'b0;
         MEM8_LANE_ONEHOT         <= 4'h0;
         WAKE_SET                 <= 1'b0;
      end else begin
         // sampled copy of the oscillator: fine for a reference, not a low-jitter clock
         CRYSTAL_CLOCK_OUTPUT_PIN <= xtal_en_r && osc_s2;
         SERIAL_ROM_CLOCK_PIN     <= rom_clk_r;
         SERIAL_ROM_SELECT_PIN    <= rom_sel_r;
         SERIAL_ROM_DATA_OUT_PIN  <= rom_do_r;
         // one lane map for the local bus, all zero when the bus is 32-bit
         MEM8_LANE_ONEHOT <= BUS_IS_32 ? 4'h0 : (4'h1 << lane_r);
         WAKE_SET <= wake_en_r && (mio_s2 ^ WAKE_POLARITY);
      end
   end

   // ==========================================================
   // checks
   sequence s_reload_write;
      set_reload && !reload_r;
   endsequence

   sequence s_reload_pulse;
      (RELOAD_START && reload_r) ##1 !RELOAD_START;
   endsequence

   a_io_byte_only: assert property (@(posedge CLOCK) disable iff (!RSTN)
      REQ.valid && !REQ.mem && !onehot4(REQ.be) |=> ACK && ERR)
      else $error("wide i/o access not refused");

   a_unmapped_zero: assert property (@(posedge CLOCK) disable iff (!RSTN)
      REQ.valid && !REQ.wr && !hit |=> ACK && (RDATA == LCCR_ZERO32))
      else $error("unmapped read not zero");

   a_mode_readback: assert property (@(posedge CLOCK) disable iff (!RSTN)
      REQ.valid && !REQ.wr && !REQ.mem && hit && (REQ.be == 4'h1)
      |=> RDATA[1:0] == $past(mode_s2))
      else $error("mode bits do not follow pins");

   a_xtal_gated: assert property (@(posedge CLOCK) disable iff (!RSTN)
      !xtal_en_r [*2] |=> !CRYSTAL_CLOCK_OUTPUT_PIN)
      else $error("crystal output not held low");

   a_lane_select: assert property (@(posedge CLOCK) disable iff (!RSTN)
      !BUS_IS_32 |=> MEM8_LANE_ONEHOT == (4'h1 << $past(lane_r)))
      else $error("lane select wrong");

   a_lane_ignored: assert property (@(posedge CLOCK) disable iff (!RSTN)
      BUS_IS_32 |=> MEM8_LANE_ONEHOT == 4'h0)
      else $error("lane select used on 32-bit bus");

   a_reserved_zero: assert property (@(posedge CLOCK) disable iff (!RSTN)
      REQ.valid && !REQ.wr && REQ.mem |=> RDATA[23:8] == 16'h0000 && RDATA[30:29] == 2'h0)
      else $error("reserved bits not zero");

   a_wake_gate: assert property (@(posedge CLOCK) disable iff (!RSTN)
      !wake_en_r |=> !WAKE_SET)
      else $error("wake set while disabled");

   a_rom_clock: assert property (@(posedge CLOCK) disable iff (!RSTN)
      wmask[3] |=> ##1 SERIAL_ROM_CLOCK_PIN == $past(wdata_reg[LCCR_B_ROM_CLK], 2))
      else $error("rom clock pin does not follow write");

   a_reload_start: assert property (@(posedge CLOCK) disable iff (!RSTN)
      s_reload_write |=> s_reload_pulse)
      else $error("reload start pulse missing");

   a_reload_clear: assert property (@(posedge CLOCK) disable iff (!RSTN)
      LOAD_DONE && !set_reload |=> !reload_r)
      else $error("reload bit not self-cleared");
endmodule

// file: bench/lccr_rom_model.sv
// Purpose: serial rom and configuration loader as seen from the register
// Assumes: software drives the rom pins bit by bit through the register
// Notes:   data in toggles while deselected, so a stale bit never reads back
`timescale 1ns/100ps
module lccr_rom_model
   import lccr_pkg::*;
(
   // clock and reset
   input  wire logic  clk,
   input  wire logic  rst_n,
   // rom pins
   input  wire logic  sck,
   input  wire logic  sel,
   input  wire logic  sdo,
   output logic       sdi,
   // loader
   input  wire logic  start,
   output lccr_load_t load,
   output logic       done
);
   // ==========
   // rom echo: returns the bit shifted in on the last rising serial clock
   logic       sck_r;
   logic [3:0] cnt_r;
   always_ff @(posedge clk) begin
      sck_r <= sck;
      if (!rst_n)
         sdi <= 1'b0;
      else if (!sel)
         sdi <= ~sdi;
      else if (sck && !sck_r)
         sdi <= sdo;
   end
   // ==========
   // loader: slow on purpose, so the reload bit must stay up meanwhile
   always_ff @(posedge clk) begin
      load <= '0;
      done <= 1'b0;
      if (!rst_n)
         cnt_r <= 4'h0;
      else if (start)
         cnt_r <= 4'h6;
      else if (cnt_r != 4'h0) begin
         cnt_r <= cnt_r - 4'h1;
         if (cnt_r == 4'h1) begin
            load <= 5'h1C;
            done <= 1'b1;
         end
      end
   end
endmodule

// file: bench/tb_lccr_ctrl.sv
// Purpose: self-checking bench of the configuration and control register
// Assumes: 100 MHz clock, inputs driven 1 ns after the rising edge
// Notes:   bit 27 follows the rom model and is masked where not under test
`timescale 1ns/100ps
module tb_lccr_ctrl import lccr_pkg::*;;
   // ==========
   // signals
   logic        clk = 0, rst_n = 0, osc = 0, mp2 = 0, b32 = 0, pol = 0, rv = 1;
   logic        ack, err, rs, done, xo, sck, sel, sdo, sdi, wake;
   logic [1:0]  mode = 2'h2;
   logic [3:0]  l1h;
   logic [31:0] rdata, rd;
   lccr_req_t   req = '0;
   lccr_load_t  load;
   int          miscompares = 0, checks_done = 0, cyc = 0, starts = 0, k;
   localparam logic [31:0] M = 32'hF7FF_FFFF;
   localparam logic [7:0]  SEQ [3] = '{8'h02, 8'h03, 8'h02};
   lccr_ctrl i_lccr_ctrl (.CLOCK(clk), .RSTN(rst_n), .REQ(req), .ACK(ack), .ERR(err),
      .RDATA(rdata), .LOAD(load), .ROM_VALID(rv), .LOAD_DONE(done), .RELOAD_START(rs),
      .MODE_PINS(mode), .XTAL_OSC(osc), .CRYSTAL_CLOCK_OUTPUT_PIN(xo),
      .SERIAL_ROM_CLOCK_PIN(sck), .SERIAL_ROM_SELECT_PIN(sel), .SERIAL_ROM_DATA_OUT_PIN(sdo),
      .SERIAL_ROM_DATA_IN_PIN(sdi), .MULTIPURPOSE_PIN_TWO(mp2), .BUS_IS_32(b32),
      .WAKE_POLARITY(pol), .MEM8_LANE_ONEHOT(l1h), .WAKE_SET(wake));
   lccr_rom_model i_lccr_rom_model (.clk(clk), .rst_n(rst_n), .sck(sck), .sel(sel),
      .sdo(sdo), .sdi(sdi), .start(rs), .load(load), .done(done));
   // ==========
   // clock, oscillator, timeout
   always #5 clk = ~clk;
   always @(posedge clk) #1 osc = ~osc;
   always @(posedge clk) begin
      cyc++;
      if (rs === 1'b1)
         starts++;
      if (cyc == 3000) begin
         miscompares++;
         end_of_test();
      end
   end
   // ==========
   // tasks
   function automatic logic [31:0] sw(input logic [31:0] v);
      return {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // an idle cycle before each request keeps valid from being driven twice at once
   task automatic acc(input logic m, input logic w, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] wd);
      @(posedge clk);
      #1 req = '{1'b1, m, w, a, be, wd};
      @(posedge clk);
      #1 req.valid = 1'b0;
      rd = rdata;
      chk(32'({ack, err}), 32'({1'b1, !m && !$onehot(be)}));
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rm(input logic [31:0] exp);
      acc(1'b1, 1'b0, 8'h00, 4'hF, '0);
      chk(sw(rd) & M, exp);
   endtask
   task automatic xc(input int n);
      k = 0;
      repeat (4) begin
         tk(1);
         k += int'(xo === 1'b1);
      end
      chk(32'(k), 32'(n));
   endtask
   // ==========
   // scenarios
   initial begin
      tk(3);
      rst_n = 1;
      tk(3);
      rm(32'h1000_0002);
      acc(1'b1, 1'b1, 8'h00, 4'hF, sw(32'h07FF_FFFC));
      rm(32'h1700_009E);
      chk({29'h0, sck, sel, sdo}, 32'h7);
      chk(32'(l1h), 32'h8);
      acc(1'b0, 1'b0, 8'h00, 4'h1, '0);
      chk(rd, 32'h9E);
      acc(1'b0, 1'b0, 8'h03, 4'h8, '0);
      chk(rd & M, 32'h1700_0000);
      acc(1'b0, 1'b1, 8'h00, 4'h3, '0);
      chk(32'(err), 32'h1);
      acc(1'b1, 1'b1, 8'h04, 4'hF, '0);
      acc(1'b1, 1'b0, 8'h04, 4'hF, '0);
      chk(rd, 32'h0);
      rm(32'h1700_009E);
      for (int l = 0; l < 4; l++) begin
         acc(1'b0, 1'b1, 8'h00, 4'h1, 32'(l << 3));
         tk(1);
         chk(32'(l1h), 32'h1 << l);
      end
      b32 = 1;
      tk(2);
      chk(32'(l1h), 32'h0);
      b32 = 0;
      xc(0);
      acc(1'b0, 1'b1, 8'h00, 4'h1, 32'h04);
      tk(3);
      xc(2);
      acc(1'b0, 1'b1, 8'h00, 4'h1, 32'h80);
      mp2 = 1;
      tk(4);
      chk(32'(wake), 32'h1);
      pol = 1;
      tk(2);
      chk(32'(wake), 32'h0);
      pol = 0;
      acc(1'b0, 1'b1, 8'h00, 4'h1, 32'h00);
      tk(2);
      chk(32'(wake), 32'h0);
      for (int d = 1; d >= 0; d--) begin
         foreach (SEQ[i])
            acc(1'b0, 1'b1, 8'h03, 4'h8, {SEQ[i] | 8'(d << 2), 24'h0});
         tk(3);
         acc(1'b0, 1'b0, 8'h03, 4'h8, '0);
         chk(32'(rd[27]), 32'(d));
      end
      acc(1'b1, 1'b1, 8'h00, 4'h1, 32'h20);
      rm(32'h3000_0002);
      tk(10);
      rm(32'h1000_0016);
      chk(32'(starts), 32'h1);
      // no valid program and new mode pins must show on the next reads
      rv = 0;
      mode = 2'h1;
      tk(3);
      rm(32'h0000_0015);
      end_of_test();
   end
endmodule
